// ===== inc/rwb_pkg.sv
// runtime wake register bank: offsets, reset values, field positions, types
package rwb_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam logic [15:0] BLOCK_SIZE = 16'h0080;

	// offsets of the registers with behaviour of their own
	localparam logic [7:0] OFF_WAKE_STS = 8'h00;
	localparam logic [7:0] OFF_WAKE_EN = 8'h02;
	localparam logic [7:0] OFF_SRC_STS4 = 8'h07;
	localparam logic [7:0] OFF_SRC_STS5 = 8'h08;
	localparam logic [7:0] OFF_SMI_STS1 = 8'h10;
	localparam logic [7:0] OFF_SYSMGMT_IRQ_STATUS_4 = 8'h13;
	localparam logic [7:0] OFF_TACH1 = 8'h59;
	localparam logic [7:0] OFF_TACH2 = 8'h5A;

	// values after standby power-on reset
	localparam logic [7:0] RST_WAKE_STS = 8'h00;
	localparam logic [7:0] RST_WAKE_EN = 8'h00;
	localparam logic [7:0] RST_SRC_STS = 8'h00;
	localparam logic [7:0] RST_SMI_STS1 = 8'h02;
	localparam logic [7:0] RST_TACH = 8'h00;

	// field positions
	localparam int unsigned WAKE_FLAG_BIT = 0;
	localparam int unsigned WAKE_EN_BIT = 0;
	localparam int unsigned PP_IRQ_BIT = 1;
	localparam int unsigned PIN32_STS_BIT = 2;
	localparam int unsigned PIN33_STS_BIT = 3;
	localparam int unsigned PIN53_STS_BIT = 3;
	localparam int unsigned PIN_DIR_IN_BIT = 0;
	localparam int unsigned LOCK_SEL_LSB = 2;
	localparam logic [1:0] LOCK_SEL_VAL = 2'h1;

	// plain read/write byte registers
	localparam int unsigned NUM_RW = 44;
	localparam int unsigned IDX_DEV_DIS = 0;
	localparam int unsigned IDX_PIN32 = 10;
	localparam int unsigned IDX_PIN33 = 11;
	localparam int unsigned IDX_PIN43 = 19;
	localparam int unsigned IDX_PIN53 = 23;

	localparam logic [7:0] RW_OFF [NUM_RW] = '{
		8'h22, 8'h2B, 8'h2C, 8'h2D, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33,
		8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C,
		8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
		8'h46, 8'h47, 8'h48, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h50,
		8'h56, 8'h57, 8'h58, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F};
	// standby reset values
	localparam logic [7:0] RW_RST [NUM_RW] = '{
		8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h01, 8'h01, 8'h05, 8'h04, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// bits that main-supply reset and hard reset also load
	localparam logic [7:0] RW_MMASK [NUM_RW] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h0C, 8'h00, 8'h08, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// value loaded into those bits
	localparam logic [7:0] RW_MVAL [NUM_RW] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} rwb_io_req_t;

	typedef logic [7:0] rwb_byte_t;

endpackage

// ===== design/rwb_byte_reg.sv
// one read/write byte register with standby and main-supply reset values
`timescale 1ns/10ps
`default_nettype none
module rwb_byte_reg #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MAIN_MASK = 8'h00,
	parameter logic [7:0] MAIN_VAL = 8'h00
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic main_rst_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] q_o
);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= RST_VAL;
		end else if (main_rst_i) begin
			// only the masked bits see main-supply and hard reset
			q_o <= (q_o & ~MAIN_MASK) | (MAIN_VAL & MAIN_MASK);
		end else if (wr_i) begin
			q_o <= wdata_i;
		end
	end

endmodule
`default_nettype wire

// ===== design/rwb_top.sv
// runtime wake register bank: host byte port, wake flag and output, registers
`timescale 1ns/10ps
`default_nettype none
module rwb_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire rwb_pkg::rwb_io_req_t io_req_i,
	input wire logic [rwb_pkg::ADDR_W-1:0] base_addr_i,
	input wire logic vcc_por_i,
	input wire logic hard_rst_i,
	input wire logic pin43_i,
	input wire logic wake_event_i,
	input wire logic pp_irq_i,
	input wire logic pp_activate_i,
	input wire logic [7:0] tach1_i,
	input wire logic [7:0] tach2_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic wake_event_out_n_o,
	output logic wake_event_oe_o,
	output logic fallback_o,
	output var rwb_pkg::rwb_byte_t rw_regs_o [rwb_pkg::NUM_RW]
);
	import rwb_pkg::*;

	// pin synchronisers; stage one is read by stage two only
	logic vcc_por_m;
	logic vcc_por_s;
	logic hard_rst_m;
	logic hard_rst_s;
	logic pin43_m;
	logic pin43_s;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vcc_por_m <= 1'b0;
			vcc_por_s <= 1'b0;
			hard_rst_m <= 1'b0;
			hard_rst_s <= 1'b0;
			pin43_m <= 1'b0;
			pin43_s <= 1'b0;
		end else begin
			vcc_por_m <= vcc_por_i;
			vcc_por_s <= vcc_por_m;
			hard_rst_m <= hard_rst_i;
			hard_rst_s <= hard_rst_m;
			pin43_m <= pin43_i;
			pin43_s <= pin43_m;
		end
	end

	logic main_rst;
	assign main_rst = vcc_por_s | hard_rst_s;

	// address decode: offset is relative to the programmed base
	logic [15:0] rel_addr;
	logic in_block;
	logic [7:0] off;
	logic wr_hit;
	logic rd_hit;

	assign rel_addr = io_req_i.addr - base_addr_i;
	assign in_block = rel_addr < BLOCK_SIZE;
	assign off = rel_addr[7:0];
	assign wr_hit = io_req_i.wr & in_block;
	assign rd_hit = io_req_i.rd & in_block;

	// plain read/write registers
	logic [7:0] rw_q [NUM_RW];
	logic [NUM_RW-1:0] rw_wr;
	logic dev_dis_lock;

	// lock only when the select field is 01 and the pin reads high
	assign dev_dis_lock = (rw_q[IDX_PIN43][LOCK_SEL_LSB +: 2] == LOCK_SEL_VAL)
		& pin43_s;

	always_comb begin
		for (int i = 0; i < NUM_RW; i++) begin
			rw_wr[i] = wr_hit & (off == RW_OFF[i]);
		end
		if (dev_dis_lock) begin
			rw_wr[IDX_DEV_DIS] = 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_RW; g++) begin : g_rw
			rwb_byte_reg #(
				.RST_VAL(RW_RST[g]),
				.MAIN_MASK(RW_MMASK[g]),
				.MAIN_VAL(RW_MVAL[g])
			) u_reg (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.main_rst_i(main_rst),
				.wr_i(rw_wr[g]),
				.wdata_i(io_req_i.wdata),
				.q_o(rw_q[g])
			);
			assign rw_regs_o[g] = rw_q[g];
		end
	endgenerate

	// wake status flag and enable; main-supply and hard reset leave them alone
	logic wake_flag;
	logic wake_en;
	logic wake_clr;

	assign wake_clr = wr_hit & (off == OFF_WAKE_STS)
		& io_req_i.wdata[WAKE_FLAG_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_flag <= RST_WAKE_STS[WAKE_FLAG_BIT];
		end else if (wake_event_i) begin
			// set wins over a clear in the same cycle, no event is lost
			wake_flag <= 1'b1;
		end else if (wake_clr) begin
			wake_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_en <= RST_WAKE_EN[WAKE_EN_BIT];
		end else if (wr_hit && off == OFF_WAKE_EN) begin
			wake_en <= io_req_i.wdata[WAKE_EN_BIT];
		end
	end

	// open-drain style wake output: drive low only when flag and enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_event_out_n_o <= 1'b1;
			wake_event_oe_o <= 1'b0;
		end else begin
			wake_event_out_n_o <= ~(wake_flag & wake_en);
			wake_event_oe_o <= wake_flag & wake_en;
		end
	end

	// pin 32, 33 and 53 status bits that main-supply reset can set
	logic [1:0] src4_sts;
	logic src5_sts;
	logic [1:0] smi4_sts;
	logic [1:0] pin_in_3233;
	logic pin_in_53;
	logic src4_wr;
	logic src5_wr;
	logic smi4_wr;

	assign pin_in_3233 = {rw_q[IDX_PIN33][PIN_DIR_IN_BIT],
		rw_q[IDX_PIN32][PIN_DIR_IN_BIT]};
	assign pin_in_53 = rw_q[IDX_PIN53][PIN_DIR_IN_BIT];
	assign src4_wr = wr_hit & (off == OFF_SRC_STS4);
	assign src5_wr = wr_hit & (off == OFF_SRC_STS5);
	assign smi4_wr = wr_hit & (off == OFF_SYSMGMT_IRQ_STATUS_4);

	// pins revert to outputs as main supply drops, so inputs see an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src4_sts <= RST_SRC_STS[PIN33_STS_BIT:PIN32_STS_BIT];
		end else begin
			src4_sts <= (src4_sts
				& ~(src4_wr ? io_req_i.wdata[PIN33_STS_BIT:PIN32_STS_BIT]
				: 2'h0))
				| (vcc_por_s ? pin_in_3233 : 2'h0);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smi4_sts <= RST_SRC_STS[PIN33_STS_BIT:PIN32_STS_BIT];
		end else begin
			smi4_sts <= (smi4_sts
				& ~(smi4_wr ? io_req_i.wdata[PIN33_STS_BIT:PIN32_STS_BIT]
				: 2'h0))
				| (vcc_por_s ? pin_in_3233 : 2'h0);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src5_sts <= RST_SRC_STS[PIN53_STS_BIT];
		end else if (vcc_por_s && pin_in_53) begin
			src5_sts <= 1'b1;
		end else if (src5_wr && io_req_i.wdata[PIN53_STS_BIT]) begin
			src5_sts <= 1'b0;
		end
	end

	// pins 32, 33, 53 use the fallback output function while main is down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fallback_o <= 1'b0;
		end else begin
			fallback_o <= vcc_por_s;
		end
	end

	// parallel-port interrupt status, forced while the port is inactive
	logic pp_irq_sts;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pp_irq_sts <= RST_SMI_STS1[PP_IRQ_BIT];
		end else if (!pp_activate_i || pp_irq_i) begin
			pp_irq_sts <= 1'b1;
		end else if (wr_hit && off == OFF_SMI_STS1
			&& io_req_i.wdata[PP_IRQ_BIT]) begin
			pp_irq_sts <= 1'b0;
		end
	end

	// tachometer counts are read-only snapshots of the fan logic
	logic [7:0] tach1_q;
	logic [7:0] tach2_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tach1_q <= RST_TACH;
			tach2_q <= RST_TACH;
		end else begin
			tach1_q <= tach1_i;
			tach2_q <= tach2_i;
		end
	end

	// read multiplexer; anything not decoded reads zero
	logic [7:0] next_rd_data;

	always_comb begin
		next_rd_data = 8'h00;
		case (off)
			OFF_WAKE_STS: begin
				next_rd_data[WAKE_FLAG_BIT] = wake_flag;
			end
			OFF_WAKE_EN: begin
				next_rd_data[WAKE_EN_BIT] = wake_en;
			end
			OFF_SRC_STS4: begin
				next_rd_data[PIN33_STS_BIT:PIN32_STS_BIT] = src4_sts;
			end
			OFF_SRC_STS5: begin
				next_rd_data[PIN53_STS_BIT] = src5_sts;
			end
			OFF_SMI_STS1: begin
				next_rd_data[PP_IRQ_BIT] = pp_irq_sts;
			end
			OFF_SYSMGMT_IRQ_STATUS_4: begin
				next_rd_data[PIN33_STS_BIT:PIN32_STS_BIT] = smi4_sts;
			end
			OFF_TACH1: begin
				next_rd_data = tach1_q;
			end
			OFF_TACH2: begin
				next_rd_data = tach2_q;
			end
			default: begin
				for (int i = 0; i < NUM_RW; i++) begin
					if (off == RW_OFF[i]) begin
						next_rd_data = rw_q[i];
					end
				end
			end
		endcase
	end

	// one-cycle read answer; writes give none
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= rd_hit;
			rd_data_o <= rd_hit ? next_rd_data : 8'h00;
		end
	end

endmodule
`default_nettype wire

// ===== tb/rwb_properties.sv
// port assertions for the runtime wake register bank
`timescale 1ns/10ps
`default_nettype none
module rwb_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire rwb_pkg::rwb_io_req_t io_req_i,
	input wire logic [rwb_pkg::ADDR_W-1:0] base_addr_i,
	input wire logic vcc_por_i,
	input wire logic wake_event_i,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic wake_event_out_n_o,
	input wire logic wake_event_oe_o,
	input wire logic fallback_o
);
	import rwb_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [15:0] off;
	logic in_blk;
	logic rd_in;
	logic en_m;
	assign off = io_req_i.addr - base_addr_i;
	assign in_blk = off < BLOCK_SIZE;
	assign rd_in = io_req_i.rd && in_blk;
	// enable mirror from host writes, so the pin can be judged alone
	always_ff @(posedge clk_i) begin
		if (rst_i)
			en_m <= 1'b0;
		else if (io_req_i.wr && in_blk && off == 16'h0002)
			en_m <= io_req_i.wdata[0];
	end
	sequence s_armed;
		wake_event_i && en_m && !io_req_i.wr ##1 1'b1;
	endsequence
	sequence s_cleared;
		io_req_i.wr && in_blk && off == 16'h0000 && io_req_i.wdata[0]
			&& !wake_event_i ##1 !wake_event_i;
	endsequence
	chk_read_answer: assert property (rd_in |=> rd_valid_o)
		else $error("read not answered");
	chk_outside_quiet: assert property (!rd_in |=> !rd_valid_o)
		else $error("answer without read");
	chk_data_idle: assert property (!rd_valid_o |-> rd_data_o == 8'h00)
		else $error("data without valid");
	chk_reserved_zero: assert property (rd_in && off[7:0] inside {8'h01,
		8'h03, 8'h2E, 8'h49, 8'h4A, [8'h51:8'h55], [8'h60:8'h7F]}
		|=> rd_data_o == 8'h00) else $error("reserved read not zero");
	chk_wake_drive: assert property (s_armed |=> !wake_event_out_n_o)
		else $error("wake output not driven");
	chk_wake_gate: assert property (!en_m |=> wake_event_out_n_o)
		else $error("wake output driven while disabled");
	chk_flag_release: assert property (s_cleared |=> !wake_event_oe_o)
		else $error("wake output held after clear");
	chk_oe_pair: assert property (wake_event_oe_o != wake_event_out_n_o)
		else $error("enable and level disagree");
	chk_fallback_on: assert property (vcc_por_i [*4] |-> fallback_o)
		else $error("fallback missing");
	chk_fallback_off: assert property (!vcc_por_i [*4] |-> !fallback_o)
		else $error("fallback stuck");
endmodule
bind rwb_top rwb_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.io_req_i(io_req_i), .base_addr_i(base_addr_i), .vcc_por_i(vcc_por_i),
	.wake_event_i(wake_event_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .wake_event_out_n_o(wake_event_out_n_o),
	.wake_event_oe_o(wake_event_oe_o), .fallback_o(fallback_o));
`default_nettype wire

// ===== tb/rwb_host_model.sv
// host model issuing single-byte runtime register cycles
`timescale 1ns/10ps
`default_nettype none
module rwb_host_model (
	input wire logic clk_i,
	input wire logic [rwb_pkg::ADDR_W-1:0] base_i,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output var rwb_pkg::rwb_io_req_t req_o
);
	import rwb_pkg::*;
	initial req_o = '0;
	// an idle cycle follows each access, so strobes never retrigger at once
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		req_o <= '{1'b0, 1'b1, base_i + {8'h00, o}, d};
		@(posedge clk_i);
		req_o <= '0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] o, output logic [7:0] d,
		output logic v);
		req_o <= '{1'b1, 1'b0, base_i + {8'h00, o}, 8'h00};
		@(posedge clk_i);
		req_o <= '0;
		@(negedge clk_i);
		v = rd_valid_i;
		d = rd_data_i;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ===== tb/runtime_wake_register_bank_tb_top.sv
// self-checking bench for the runtime wake register bank
`timescale 1ns/10ps
`default_nettype none
module runtime_wake_register_bank_tb_top;
	import rwb_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	rwb_io_req_t req;
	logic [15:0] base = 16'h0A00;
	logic vcc = 0, hrst = 0, pin43 = 0, wev = 0, ppi = 0, ppa = 0;
	logic [7:0] tach1 = 8'h3C, tach2 = 8'hC3, rdat, d;
	logic rvld, out_n, oe, fb, v;
	rwb_byte_t regs [NUM_RW];
	int miscompares = 0, total_checks = 0;
	always #5 clk_i = ~clk_i;
	rwb_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .io_req_i(req),
		.base_addr_i(base), .vcc_por_i(vcc), .hard_rst_i(hrst),
		.pin43_i(pin43), .wake_event_i(wev), .pp_irq_i(ppi),
		.pp_activate_i(ppa), .tach1_i(tach1), .tach2_i(tach2),
		.rd_data_o(rdat), .rd_valid_o(rvld), .wake_event_out_n_o(out_n),
		.wake_event_oe_o(oe), .fallback_o(fb), .rw_regs_o(regs));
	rwb_host_model i_host (.clk_i(clk_i), .base_i(base),
		.rd_data_i(rdat), .rd_valid_i(rvld), .req_o(req));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] o, input logic [7:0] exp);
		i_host.rd(o, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask
	task automatic t_reset;
		for (int i = 0; i < NUM_RW; i++)
			rchk(RW_OFF[i], RW_RST[i]);
		rchk(OFF_TACH1, tach1);
		rchk(OFF_TACH2, tach2);
		$display("test reset done");
	endtask
	task automatic t_reserved;
		logic [7:0] rsv [6] = '{8'h01, 8'h2E, 8'h49, 8'h53, 8'h60, 8'h7F};
		foreach (rsv[i]) begin
			i_host.wr(rsv[i], 8'hFF);
			rchk(rsv[i], 8'h00);
		end
		i_host.rd(8'h80, d, v);
		chk({7'h00, v}, 8'h00);
		$display("test reserved done");
	endtask
	task automatic t_lock;
		i_host.wr(8'h3E, 8'h05);
		pin43 <= 1'b1;
		cyc(4);
		i_host.wr(8'h22, 8'hAA);
		rchk(8'h22, 8'h00);
		pin43 <= 1'b0;
		cyc(4);
		i_host.wr(8'h22, 8'hAA);
		rchk(8'h22, 8'hAA);
		chk(regs[IDX_DEV_DIS], 8'hAA);
		$display("test lock done");
	endtask
	task automatic t_pp;
		rchk(OFF_SMI_STS1, 8'h02);
		ppa <= 1'b1;
		cyc(1);
		i_host.wr(OFF_SMI_STS1, 8'h02);
		rchk(OFF_SMI_STS1, 8'h00);
		ppi <= 1'b1;
		cyc(1);
		ppi <= 1'b0;
		rchk(OFF_SMI_STS1, 8'h02);
		$display("test parallel done");
	endtask
	task automatic t_wake;
		for (int k = 0; k < 2; k++) begin
			wev <= 1'b1;
			cyc(1);
			wev <= 1'b0;
			cyc(3);
			chk({6'h00, oe, out_n}, k ? 8'h02 : 8'h01);
			rchk(OFF_WAKE_STS, 8'h01);
			i_host.wr(OFF_WAKE_STS, 8'hFE);
			rchk(OFF_WAKE_STS, 8'h01);
			i_host.wr(OFF_WAKE_EN, 8'h01);
			if (k == 0) begin
				i_host.wr(OFF_WAKE_STS, 8'h01);
				cyc(1);
				chk({6'h00, oe, out_n}, 8'h01);
				rchk(OFF_WAKE_STS, 8'h00);
			end
		end
		$display("test wake done");
	endtask
	task automatic t_main;
		logic [7:0] o [5] = '{8'h3E, 8'h4C, 8'h4F, 8'h35, 8'h38};
		logic [7:0] e [5] = '{8'hF3, 8'hF3, 8'hF7, 8'h00, 8'h04};
		for (int k = 0; k < 2; k++) begin
			foreach (o[i])
				i_host.wr(o[i], 8'hFF);
			if (k == 0)
				vcc <= 1'b1;
			else
				hrst <= 1'b1;
			cyc(6);
			chk({7'h00, fb}, k ? 8'h00 : 8'h01);
			vcc <= 1'b0;
			hrst <= 1'b0;
			cyc(4);
			foreach (o[i])
				rchk(o[i], e[i]);
			chk(regs[IDX_PIN43], 8'hF3);
			chk(regs[IDX_PIN53], 8'h00);
			rchk(OFF_WAKE_STS, 8'h01);
			rchk(OFF_WAKE_EN, 8'h01);
			rchk(OFF_SRC_STS4, 8'h0C);
			rchk(OFF_SYSMGMT_IRQ_STATUS_4, 8'h0C);
			rchk(OFF_SRC_STS5, 8'h00);
		end
		// only the standby reset may clear the wake bits
		rst_i <= 1'b1;
		cyc(6);
		rst_i <= 1'b0;
		rchk(OFF_WAKE_STS, 8'h00);
		rchk(OFF_WAKE_EN, 8'h00);
		rchk(8'h3E, 8'h01);
		$display("test main reset done");
	endtask
	task automatic conclude;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(6);
		rst_i <= 1'b0;
		t_reset();
		t_reserved();
		t_lock();
		t_pp();
		t_wake();
		t_main();
		conclude();
	end
endmodule
`default_nettype wire
